// ### verilog/temp_monitor_pkg.sv
// constants shared by the two-channel temperature monitor
package temp_monitor_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    // serial link timing
    localparam int SPIKE_NS = 50;
    localparam int CLK_NS = 20;
    localparam int GLITCH_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS + 1; // stable samples needed
    localparam int TIMEOUT_MIN_MS = 25;
    localparam int TIMEOUT_MAX_MS = 55;
    localparam logic [5:0] TIMEOUT_MS = 6'(TIMEOUT_MIN_MS + 5);
    // conversion timing, in ms
    localparam logic [15:0] INTEG_MS = 16'd60;
    localparam logic [15:0] RATE_UNIT_MS = 16'd125;
    // register offsets
    localparam logic [7:0] OFS_LOCAL_INT = 8'h00;
    localparam logic [7:0] OFS_REMOTE_INT = 8'h01;
    localparam logic [7:0] OFS_STATUS = 8'h02;
    localparam logic [7:0] OFS_CONFIG = 8'h03;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] OFS_LOCAL_LOW = 8'h06;
    localparam logic [7:0] OFS_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] OFS_REMOTE_LOW = 8'h08;
    localparam logic [7:0] OFS_ONE_SHOT = 8'h0F;
    localparam logic [7:0] OFS_REMOTE_FRAC = 8'h10;
    localparam logic [7:0] OFS_LOCAL_FRAC = 8'h11;
    localparam logic [7:0] OFS_REMOTE_OVER = 8'h19;
    localparam logic [7:0] OFS_LOCAL_OVER = 8'h20;
    // field positions
    localparam int CFG_STANDBY_BIT = 6;
    localparam int ST_BUSY = 7;
    localparam int ST_LHIGH = 6;
    localparam int ST_LLOW = 5;
    localparam int ST_RHIGH = 4;
    localparam int ST_RLOW = 3;
    localparam int ST_FAULT = 2;
    // reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h07;
    localparam logic [7:0] RST_HIGH = 8'h46;
    localparam logic [7:0] RST_LOW = 8'h00;
    localparam logic [7:0] RST_OVER = 8'h55;
    localparam logic [7:0] CODE_FAULT = 8'hFF;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
endpackage : temp_monitor_pkg

// ### verilog/temp_monitor.sv
// two-channel temperature monitor: sequencer, result registers, alarms, serial slave
// Behaviour
// - serial state resets after long clock-low stall
// - spikes up to 50 ns on scl and sda inputs ignored
// - overtemp pin low while temperature over limit
// - alert on high or low limit crossing
// - alert held until acknowledged and condition gone
// - alert also on remote diode fault, only while LOW_LIMIT_EN is set
// - alert and overtemp pins are open drain
// - free-running and single-shot conversion modes
// - every conversion covers both channels
// - each channel integrates for 60 ms
// - results are 11 bits, eighth-degree steps
// - integer bytes at offsets 00h and 01h
// - diode fault loads all-ones remote integer byte
// - fraction bits left-justified at 11h, 10h
// - busy bit set, old results stay readable
// - main and extended bytes update together
// - standby aborts conversion without latching results
`timescale 1ns/1ps
`default_nettype none
module temp_monitor #(
    parameter int MS_CYC = temp_monitor_pkg::CLK_HZ / temp_monitor_pkg::MS_PER_S,
    parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
    parameter bit LOW_LIMIT_EN = 1'b1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic adc_clk_in,
    input wire logic adc_valid_in,
    input wire logic [11:0] adc_local_in,
    input wire logic [11:0] adc_remote_in,
    input wire logic adc_fault_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic alert_out,
    output logic alert_oe_out,
    output logic overtemp_out,
    output logic overtemp_oe_out
);
    // signed code, 1/8 degree per step; negatives clamp to zero
    function automatic logic [7:0] enc_main(input logic [11:0] c);
        return c[11] ? temp_monitor_pkg::CODE_ZERO : c[10:3];
    endfunction : enc_main
    function automatic logic [7:0] enc_frac(input logic [11:0] c);
        return c[11] ? 8'h00 : {c[2:0], 5'h00};
    endfunction : enc_frac

    // adc domain: hold the sample and flag it by a toggle
    logic [11:0] a_loc_r, a_rem_r;
    logic a_flt_r, a_tog_r;
    always_ff @(posedge adc_clk_in or posedge rst_in) begin
        if (rst_in) begin
            a_loc_r <= 12'h000;
            a_rem_r <= 12'h000;
            a_flt_r <= 1'b0;
            a_tog_r <= 1'b0;
        end else if (adc_valid_in) begin
            a_loc_r <= adc_local_in;
            a_rem_r <= adc_remote_in;
            a_flt_r <= adc_fault_in;
            a_tog_r <= ~a_tog_r;
        end
    end

    // toggle crossing; held words are stable once the toggle lands
    logic [2:0] tog_s_r;
    logic [11:0] smp_loc_r, smp_rem_r;
    logic smp_flt_r;
    wire smp_new = tog_s_r[2] ^ tog_s_r[1];
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tog_s_r <= 3'h0;
            smp_loc_r <= 12'h000;
            smp_rem_r <= 12'h000;
            smp_flt_r <= 1'b0;
        end else begin
            tog_s_r <= {tog_s_r[1:0], a_tog_r};
            if (smp_new) begin
                smp_loc_r <= a_loc_r;
                smp_rem_r <= a_rem_r;
                smp_flt_r <= a_flt_r;
            end
        end
    end

    // pin synchronisers and spike filter
    logic [1:0] scl_m_r, sda_m_r;
    logic [temp_monitor_pkg::GLITCH_CYC-1:0] scl_h_r, sda_h_r;
    logic scl_f_r, sda_f_r, scl_q_r, sda_q_r;
    wire scl_flat = (&scl_h_r) | ~(|scl_h_r);
    wire sda_flat = (&sda_h_r) | ~(|sda_h_r);
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_m_r <= 2'h3;
            sda_m_r <= 2'h3;
            scl_h_r <= '1;
            sda_h_r <= '1;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= {scl_m_r[0], scl_in};
            sda_m_r <= {sda_m_r[0], sda_in};
            scl_h_r <= {scl_h_r[temp_monitor_pkg::GLITCH_CYC-2:0], scl_m_r[1]};
            sda_h_r <= {sda_h_r[temp_monitor_pkg::GLITCH_CYC-2:0], sda_m_r[1]};
            if (scl_flat) scl_f_r <= scl_h_r[0];
            if (sda_flat) sda_f_r <= sda_h_r[0];
            scl_q_r <= scl_f_r;
            sda_q_r <= sda_f_r;
        end
    end
    wire scl_rise = scl_f_r & ~scl_q_r;
    wire scl_fall = ~scl_f_r & scl_q_r;
    wire bus_start = scl_f_r & scl_q_r & ~sda_f_r & sda_q_r;
    wire bus_stop = scl_f_r & scl_q_r & sda_f_r & ~sda_q_r;

    // millisecond tick and clock-low stall counter
    logic [31:0] ms_cnt_r;
    logic [5:0] low_ms_r;
    wire ms_tick = (ms_cnt_r == 32'(MS_CYC - 1));
    wire bus_stall = (low_ms_r == temp_monitor_pkg::TIMEOUT_MS);
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ms_cnt_r <= 32'h0;
            low_ms_r <= 6'h00;
        end else begin
            ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
            if (scl_f_r) low_ms_r <= 6'h00;
            else if (ms_tick && !bus_stall) low_ms_r <= low_ms_r + 6'h01;
        end
    end

    // serial slave state machine
    typedef enum logic [8:0] {
        B_IDLE = 9'h001, B_ADDR = 9'h002, B_AACK = 9'h004, B_CMD = 9'h008, B_CACK = 9'h010,
        B_WDAT = 9'h020, B_WACK = 9'h040, B_RDAT = 9'h080, B_MACK = 9'h100
    } bus_state_t;
    bus_state_t bst_r, bst_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rdata;
    logic oe_r, oe_nxt, rd_r, rd_nxt, ara_r, ara_nxt;
    logic wr_en, one_shot, byte_load;
    logic alert_r;
    wire [6:0] rx_addr = sh_r[7:1];
    wire addr_hit = (rx_addr == DEV_ADDR)
        | ((rx_addr == temp_monitor_pkg::ALERT_RESP_ADDR) & sh_r[0] & alert_r);
    always_comb begin
        bst_nxt = bst_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        oe_nxt = oe_r;
        rd_nxt = rd_r;
        ara_nxt = ara_r;
        wr_en = 1'b0;
        one_shot = 1'b0;
        byte_load = 1'b0;
        unique case (bst_r)
            B_IDLE: ;
            B_ADDR, B_CMD, B_WDAT: begin
                if (scl_rise) begin
                    sh_nxt = {sh_r[6:0], sda_f_r};
                    bit_nxt = bit_r + 4'h1;
                end else if (scl_fall && bit_r == 4'h8) begin
                    bit_nxt = 4'h0;
                    oe_nxt = 1'b1;
                    if (bst_r == B_ADDR) begin
                        bst_nxt = addr_hit ? B_AACK : B_IDLE;
                        oe_nxt = addr_hit;
                        rd_nxt = sh_r[0];
                        ara_nxt = (rx_addr == temp_monitor_pkg::ALERT_RESP_ADDR);
                    end else if (bst_r == B_CMD) begin
                        bst_nxt = B_CACK;
                        ptr_nxt = sh_r;
                        one_shot = (sh_r == temp_monitor_pkg::OFS_ONE_SHOT);
                    end else begin
                        bst_nxt = B_WACK;
                        wr_en = 1'b1;
                    end
                end
            end
            B_AACK: begin
                if (scl_fall) begin
                    if (rd_r) begin
                        bst_nxt = B_RDAT;
                        sh_nxt = rdata;
                        oe_nxt = ~rdata[7];
                        bit_nxt = 4'h1;
                        byte_load = 1'b1;
                    end else begin
                        bst_nxt = B_CMD;
                        oe_nxt = 1'b0;
                    end
                end
            end
            B_CACK, B_WACK: begin
                if (scl_fall) begin
                    bst_nxt = B_WDAT;
                    oe_nxt = 1'b0;
                end
            end
            B_RDAT: begin
                if (scl_fall) begin
                    if (bit_r == 4'h8) begin
                        bst_nxt = B_MACK;
                        oe_nxt = 1'b0;
                        bit_nxt = 4'h0;
                    end else begin
                        oe_nxt = ~sh_r[6];
                        sh_nxt = {sh_r[6:0], 1'b0};
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
            B_MACK: begin
                if (scl_rise && sda_f_r) bst_nxt = B_IDLE;
                else if (scl_fall) begin
                    bst_nxt = B_RDAT;
                    sh_nxt = rdata;
                    oe_nxt = ~rdata[7];
                    bit_nxt = 4'h1;
                    byte_load = 1'b1;
                end
            end
        endcase
        // stall, start and stop override the byte engine
        if (bus_stall || bus_stop) begin
            bst_nxt = B_IDLE;
            oe_nxt = 1'b0;
        end else if (bus_start) begin
            bst_nxt = B_ADDR;
            bit_nxt = 4'h0;
            oe_nxt = 1'b0;
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bst_r <= B_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            oe_r <= 1'b0;
            rd_r <= 1'b0;
            ara_r <= 1'b0;
        end else begin
            bst_r <= bst_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            oe_r <= oe_nxt;
            rd_r <= rd_nxt;
            ara_r <= ara_nxt;
        end
    end

    // writable settings
    logic [7:0] cfg_r, rate_r, lhi_r, llo_r, rhi_r, rlo_r, lot_r, rot_r;
    wire standby = cfg_r[temp_monitor_pkg::CFG_STANDBY_BIT];
    wire standby_set = wr_en && ptr_r == temp_monitor_pkg::OFS_CONFIG
        && sh_r[temp_monitor_pkg::CFG_STANDBY_BIT] && !standby;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r <= temp_monitor_pkg::RST_CONFIG;
            rate_r <= temp_monitor_pkg::RST_RATE;
            lhi_r <= temp_monitor_pkg::RST_HIGH;
            llo_r <= temp_monitor_pkg::RST_LOW;
            rhi_r <= temp_monitor_pkg::RST_HIGH;
            rlo_r <= temp_monitor_pkg::RST_LOW;
            lot_r <= temp_monitor_pkg::RST_OVER;
            rot_r <= temp_monitor_pkg::RST_OVER;
        end else if (wr_en) begin
            unique case (ptr_r)
                temp_monitor_pkg::OFS_CONFIG: cfg_r <= sh_r;
                temp_monitor_pkg::OFS_RATE: rate_r <= sh_r;
                temp_monitor_pkg::OFS_LOCAL_HIGH: lhi_r <= sh_r;
                temp_monitor_pkg::OFS_LOCAL_LOW: llo_r <= sh_r;
                temp_monitor_pkg::OFS_REMOTE_HIGH: rhi_r <= sh_r;
                temp_monitor_pkg::OFS_REMOTE_LOW: rlo_r <= sh_r;
                temp_monitor_pkg::OFS_LOCAL_OVER: lot_r <= sh_r;
                temp_monitor_pkg::OFS_REMOTE_OVER: rot_r <= sh_r;
                default: ;
            endcase
        end
    end

    // conversion sequencer
    typedef enum logic [3:0] {
        S_IDLE = 4'h1, S_LOCAL = 4'h2, S_REMOTE = 4'h4, S_GAP = 4'h8
    } seq_state_t;
    seq_state_t sst_r;
    logic [15:0] sms_r;
    logic shot_r, commit_r;
    logic [11:0] pend_loc_r;
    logic [7:0] lmain_r, lfrac_r, rmain_r, rfrac_r;
    logic rflt_r;
    wire busy = (sst_r == S_LOCAL) | (sst_r == S_REMOTE);
    wire integ_done = ms_tick && sms_r == temp_monitor_pkg::INTEG_MS - 16'h1;
    wire [15:0] gap_ms = 16'(temp_monitor_pkg::RATE_UNIT_MS * (16'(rate_r[2:0]) + 16'h1));
    wire gap_done = ms_tick && sms_r >= gap_ms - 16'h1;
    wire seq_go = !standby || shot_r;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sst_r <= S_IDLE;
            sms_r <= 16'h0;
            shot_r <= 1'b0;
            commit_r <= 1'b0;
            pend_loc_r <= 12'h000;
        end else begin
            commit_r <= 1'b0;
            if (one_shot) shot_r <= 1'b1;
            if (ms_tick) sms_r <= sms_r + 16'h1;
            unique case (sst_r)
                S_IDLE, S_GAP: if ((sst_r == S_IDLE || gap_done) && seq_go) begin
                    sst_r <= S_LOCAL;
                    sms_r <= 16'h0;
                    shot_r <= one_shot;
                end else if (sst_r == S_GAP && standby) sst_r <= S_IDLE;
                S_LOCAL: if (integ_done) begin
                    sst_r <= S_REMOTE;
                    sms_r <= 16'h0;
                    pend_loc_r <= smp_loc_r;
                end
                S_REMOTE: if (integ_done) begin
                    sst_r <= S_GAP;
                    sms_r <= 16'h0;
                    commit_r <= 1'b1;
                end
            endcase
            if (busy && standby_set) begin
                sst_r <= S_IDLE;
                commit_r <= 1'b0;
            end
        end
    end

    // result registers, both bytes of a channel in one cycle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lmain_r <= 8'h00;
            lfrac_r <= 8'h00;
            rmain_r <= 8'h00;
            rfrac_r <= 8'h00;
            rflt_r <= 1'b0;
        end else if (commit_r) begin
            lmain_r <= enc_main(pend_loc_r);
            lfrac_r <= enc_frac(pend_loc_r);
            rmain_r <= smp_flt_r ? temp_monitor_pkg::CODE_FAULT : enc_main(smp_rem_r);
            rfrac_r <= smp_flt_r ? 8'h00 : enc_frac(smp_rem_r);
            rflt_r <= smp_flt_r;
        end
    end

    // limit comparison, sticky status and alarm pins
    wire [7:0] cond;
    assign cond[temp_monitor_pkg::ST_BUSY] = 1'b0;
    assign cond[temp_monitor_pkg::ST_LHIGH] = lmain_r > lhi_r;
    assign cond[temp_monitor_pkg::ST_LLOW] = LOW_LIMIT_EN && lmain_r < llo_r;
    assign cond[temp_monitor_pkg::ST_RHIGH] = !rflt_r && rmain_r > rhi_r;
    assign cond[temp_monitor_pkg::ST_RLOW] = LOW_LIMIT_EN && !rflt_r && rmain_r < rlo_r;
    assign cond[temp_monitor_pkg::ST_FAULT] = LOW_LIMIT_EN && rflt_r;
    assign cond[1:0] = 2'h0;
    wire over_now = (lmain_r > lot_r) | (!rflt_r && rmain_r > rot_r);
    wire stat_rd = byte_load && !ara_r && ptr_r == temp_monitor_pkg::OFS_STATUS;
    wire alert_ack = byte_load && (ara_r || ptr_r == temp_monitor_pkg::OFS_STATUS);
    logic [7:0] stat_r;
    logic over_r;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            stat_r <= 8'h00;
            alert_r <= 1'b0;
            over_r <= 1'b0;
        end else begin
            stat_r <= cond | (stat_r & {8{!stat_rd}}); // set wins over the read clear
            alert_r <= (|cond) | (alert_r & !alert_ack);
            over_r <= over_now;
        end
    end

    // register read selection
    always_comb begin
        unique case (ptr_r)
            temp_monitor_pkg::OFS_LOCAL_INT: rdata = lmain_r;
            temp_monitor_pkg::OFS_REMOTE_INT: rdata = rmain_r;
            temp_monitor_pkg::OFS_LOCAL_FRAC: rdata = lfrac_r;
            temp_monitor_pkg::OFS_REMOTE_FRAC: rdata = rfrac_r;
            temp_monitor_pkg::OFS_STATUS: rdata = stat_r | {busy, 7'h00};
            temp_monitor_pkg::OFS_CONFIG: rdata = cfg_r;
            temp_monitor_pkg::OFS_RATE: rdata = rate_r;
            temp_monitor_pkg::OFS_LOCAL_HIGH: rdata = lhi_r;
            temp_monitor_pkg::OFS_LOCAL_LOW: rdata = llo_r;
            temp_monitor_pkg::OFS_REMOTE_HIGH: rdata = rhi_r;
            temp_monitor_pkg::OFS_REMOTE_LOW: rdata = rlo_r;
            temp_monitor_pkg::OFS_LOCAL_OVER: rdata = lot_r;
            temp_monitor_pkg::OFS_REMOTE_OVER: rdata = rot_r;
            default: rdata = 8'h00;
        endcase
        if (ara_r) rdata = {DEV_ADDR, 1'b0};
    end

    // open-drain pins: value low, enable while asserted
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_r;
    assign alert_out = 1'b0;
    assign alert_oe_out = alert_r;
    assign overtemp_out = 1'b0;
    assign overtemp_oe_out = over_r;

    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_stall_reset: assert property (bus_stall |=> bst_r == B_IDLE && !oe_r) else $error("stall");
    a_spike_filter: assert property (scl_f_r != scl_q_r |-> $past(scl_flat)) else $error("spike");
    a_over_level: assert property (##1 over_r == $past(over_now)) else $error("overtemp");
    a_alert_raise: assert property ((|cond) |=> alert_r) else $error("alert not set");
    a_alert_hold: assert property (alert_r && !alert_ack |=> alert_r) else $error("alert drop");
    a_fault_alert: assert property (rflt_r && LOW_LIMIT_EN |=> alert_r) else $error("fault");
    a_both_chan: assert property (sst_r == S_LOCAL && integ_done && !standby_set
        |=> sst_r == S_REMOTE) else $error("remote skipped");
    a_fault_code: assert property (commit_r && smp_flt_r |=> rmain_r == 8'hFF) else $error("fault");
    a_hold_busy: assert property (busy && !commit_r |=> $stable(lmain_r) && $stable(rfrac_r))
        else $error("results moved");
    a_abort_keep: assert property (busy && standby_set |=> sst_r == S_IDLE && !commit_r)
        else $error("abort");
    a_neg_clamp: assert property (commit_r && pend_loc_r[11] |=> lmain_r == 8'h00)
        else $error("clamp");
    c_commit: cover property (commit_r);
    c_ara_ack: cover property (alert_ack && ara_r);
    c_stall: cover property (bus_stall && bst_r != B_IDLE);
    c_abort: cover property (busy && standby_set);
endmodule : temp_monitor
`default_nettype wire

// ### sim/smbus_host_model.sv
// bus master model for the monitor's two-wire serial pins
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model #(
    parameter int PH = 12,
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out = 1'b1,
    output logic sda_out = 1'b1
);
    // set both pins just after an edge, then hold them
    task automatic drive(input logic c, input logic d);
        scl_out <= c;
        sda_out <= d;
        repeat (PH) @(posedge clk_in);
    endtask : drive
    // data moves with clock low, sampled late in clock high
    task automatic bit_io(input logic b, output logic r);
        drive(1'b0, b);
        drive(1'b1, b);
        r = sda_in;
        drive(1'b0, b);
    endtask : bit_io
    // start, also used as repeated start
    task automatic start_c;
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask : start_c
    task automatic stop_c;
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask : stop_c
    // eight bits msb first, acknowledge slot left released
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
    endtask : byte_io
    // mode 0 send byte, 1 write byte, 2 read byte ending in not-acknowledge
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, input int mode,
            output logic [7:0] q);
        start_c;
        byte_io({ADDR, 1'b0}, q);
        byte_io(cmd, q);
        if (mode == 2) begin
            start_c;
            byte_io({ADDR, 1'b1}, q);
        end
        if (mode != 0) begin
            byte_io(mode == 2 ? 8'hFF : data, q);
        end
        stop_c;
    endtask : xfer
    // receive byte from a given address, ending in not-acknowledge
    task automatic rcv(input logic [6:0] a, output logic [7:0] q);
        start_c;
        byte_io({a, 1'b1}, q);
        byte_io(8'hFF, q);
        stop_c;
    endtask : rcv
endmodule : smbus_host_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the two-channel temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_in, adc_clk, rst_in, adc_valid, adc_fault, fault_v, scl, host_sda, r;
    logic sda_o, sda_oe, al, al_oe, ot, ot_oe, sda_bus;
    logic [11:0] adc_loc, adc_rem, loc_v, rem_v;
    logic [7:0] q;
    logic [7:0] aw = 8'h54;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    // data line with pull-up: low when either party pulls
    assign sda_bus = host_sda & (sda_oe ? sda_o : 1'b1);
    temp_monitor #(.MS_CYC(50)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .adc_clk_in(adc_clk), .adc_valid_in(adc_valid), .adc_local_in(adc_loc),
        .adc_remote_in(adc_rem), .adc_fault_in(adc_fault), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .alert_out(al), .alert_oe_out(al_oe),
        .overtemp_out(ot), .overtemp_oe_out(ot_oe));
    smbus_host_model u_host (.clk_in(mclk_in), .sda_in(sda_bus), .scl_out(scl),
        .sda_out(host_sda));
    // system clock and unrelated link clock
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    initial begin
        adc_clk = 1'b0;
        #4;
        forever #7.5 adc_clk = ~adc_clk;
    end
    always @(posedge mclk_in) cyc <= cyc + 1;
    // link side: one sample word every 40 link cycles
    initial begin
        adc_valid = 1'b0;
        adc_fault = 1'b0;
        adc_loc = '0;
        adc_rem = '0;
        forever begin
            repeat (39) @(posedge adc_clk);
            adc_valid <= 1'b1;
            adc_loc <= loc_v;
            adc_rem <= rem_v;
            adc_fault <= fault_v;
            @(posedge adc_clk);
            adc_valid <= 1'b0;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic at(input int n);
        while (cyc < n) @(posedge mclk_in);
    endtask : at
    task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
        u_host.xfer(ofs, 8'h00, 2, q);
        chk(q, exp);
    endtask : rdc
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // watchdog well past the planned sequence
    initial begin
        at(80000);
        miscompares++;
        stop_test();
    end
    // main sequence on a fixed cycle schedule
    initial begin
        rst_in = 1'b1;
        loc_v = 12'h0CB;
        rem_v = 12'hFD8;
        fault_v = 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        at(20);
        rdc(temp_monitor_pkg::OFS_RATE, temp_monitor_pkg::RST_RATE);
        rdc(8'h30, 8'h00);
        rdc(8'h00, 8'h00);
        u_host.xfer(temp_monitor_pkg::OFS_RATE, 8'h00, 1, q);
        at(6500);
        rdc(8'h00, 8'h19);
        rdc(8'h11, 8'h60);
        rdc(8'h01, 8'h00);
        loc_v = 12'h320;
        fault_v = 1'b1;
        at(13000);
        u_host.xfer(temp_monitor_pkg::OFS_STATUS, 8'h00, 2, q);
        chk({7'h0, q[7]}, 8'h01);
        rdc(8'h00, 8'h19);
        at(19000);
        chk({7'h0, al_oe}, 8'h01);
        chk({7'h0, al_oe ? al : 1'b1}, 8'h00);
        chk({7'h0, ot_oe ? ot : 1'b1}, 8'h00);
        rdc(8'h01, 8'hFF);
        rdc(8'h00, 8'h64);
        loc_v = 12'h0A0;
        fault_v = 1'b0;
        at(31000);
        chk({7'h0, ot_oe}, 8'h00);
        chk({7'h0, al_oe}, 8'h01);
        u_host.xfer(temp_monitor_pkg::OFS_STATUS, 8'h00, 2, q);
        chk({7'h0, al_oe}, 8'h00);
        u_host.xfer(temp_monitor_pkg::OFS_REMOTE_LOW, 8'h05, 1, q);
        chk({7'h0, al_oe}, 8'h01);
        at(37500);
        loc_v = 12'h190;
        rem_v = 12'h0FC;
        u_host.xfer(temp_monitor_pkg::OFS_CONFIG, 8'h40, 1, q);
        at(44000);
        rdc(8'h00, 8'h14);
        u_host.xfer(temp_monitor_pkg::OFS_ONE_SHOT, 8'h00, 0, q);
        at(53500);
        rdc(8'h00, 8'h32);
        rdc(8'h01, 8'h1F);
        rdc(8'h10, 8'h80);
        // alert still latched; alert response read answers and clears it
        chk({7'h0, al_oe}, 8'h01);
        u_host.rcv(temp_monitor_pkg::ALERT_RESP_ADDR, q);
        chk(q, aw);
        chk({7'h0, al_oe}, 8'h00);
        // stall the clock low after the address byte
        u_host.start_c;
        for (int i = 7; i >= 0; i--) begin
            u_host.bit_io(aw[i], r);
        end
        at(cyc + 1200);
        chk({7'h0, sda_oe}, 8'h01);
        at(cyc + 400);
        chk({7'h0, sda_oe}, 8'h00);
        u_host.stop_c;
        rdc(8'h00, 8'h32);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
